// file: src/tve_pkg.sv
// Purpose: Shared constants and types of the video encoder register bank
// Assumes: Byte-level events come from a separate two-wire serial front end
// Notes: Offsets are register addresses; storage covers 00h..29h

// ****************************************
// Package
// ****************************************
package tve_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [5:0] A_DISPLAY_MODE = 6'h00;
    localparam logic [5:0] A_FLICKER = 6'h01;
    localparam logic [5:0] A_BANDWIDTH = 6'h03;
    localparam logic [5:0] A_INPUT_FORMAT = 6'h04;
    localparam logic [5:0] A_CLOCK_MODE = 6'h06;
    localparam logic [5:0] A_AV_DELAY = 6'h07;
    localparam logic [5:0] A_POS_OVERFLOW = 6'h08;
    localparam logic [5:0] A_BLACK_LEVEL = 6'h09;
    localparam logic [5:0] A_H_OFFSET = 6'h0a;
    localparam logic [5:0] A_V_OFFSET = 6'h0b;
    localparam logic [5:0] A_SYNC_POL = 6'h0d;
    localparam logic [5:0] A_POWER = 6'h0e;
    localparam logic [5:0] A_CONN_SENSE = 6'h10;
    localparam logic [5:0] A_CONTRAST = 6'h11;
    localparam logic [5:0] A_PLL_HIGH = 6'h13;
    localparam logic [5:0] A_PLL_FB = 6'h14;
    localparam logic [5:0] A_PLL_REF = 6'h15;
    localparam logic [5:0] A_CLK_OUT = 6'h17;
    localparam logic [5:0] A_SUBC_FIRST = 6'h18;
    localparam logic [5:0] A_SUBC_LAST = 6'h1f;
    localparam logic [5:0] A_PLL_MEM = 6'h20;
    localparam logic [5:0] A_CALC_CTRL = 6'h21;
    localparam logic [5:0] A_CALC_HI = 6'h22;
    localparam logic [5:0] A_CALC_MID = 6'h23;
    localparam logic [5:0] A_CALC_LO = 6'h24;
    localparam logic [5:0] A_VERSION = 6'h25;
    localparam logic [5:0] A_TEST_FIRST = 6'h26;
    localparam logic [5:0] A_TEST_1 = 6'h27;
    localparam logic [5:0] A_TEST_2 = 6'h28;
    localparam logic [5:0] A_TEST_LAST = 6'h29;
    localparam logic [5:0] A_POINTER = 6'h3f;
    localparam logic [5:0] A_READ_WRAP = 6'h2a;
    localparam logic [5:0] A_READ_START = 6'h00;
    localparam int MEM_DEPTH = 42;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int POS_DELAY_MSB = 2;
    localparam int POS_HPOS_MSB = 1;
    localparam int POS_VPOS_MSB = 0;
    localparam int POS_FB_BIT8 = 0;
    localparam int POS_REF_LO = 1;
    localparam int POS_REF_HI = 2;
    localparam int POS_CALC_LO = 3;
    localparam int POS_CALC_HI = 4;
    localparam int POS_STEP_EN = 6;

    // ****************************************
    // Writable bit masks
    // ****************************************
    localparam logic [7:0] M_FULL = 8'hff;
    localparam logic [7:0] M_SIX = 8'h3f;
    localparam logic [7:0] M_INPUT = 8'h6f;
    localparam logic [7:0] M_THREE = 8'h07;
    localparam logic [7:0] M_FOUR = 8'h0f;
    localparam logic [7:0] M_FIVE = 8'h1f;
    localparam logic [7:0] M_ONE = 8'h01;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_DISPLAY_MODE = 8'h6a;
    localparam logic [7:0] RST_FLICKER = 8'h32;
    localparam logic [7:0] RST_POWER = 8'h08;
    localparam logic [7:0] RST_OTHER = 8'h00;
    localparam logic [5:0] RST_POINTER = 6'h00;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [5:0] ptr;
        logic step_en;
        logic first_read;
        logic [7:0] rd_byte;
        logic [MEM_DEPTH-1:0][7:0] mem;
    } tve_state_t;

    typedef struct packed {
        logic [7:0] display_mode_select;
        logic [5:0] flicker_filter_select;
        logic [7:0] video_bandwidth;
        logic [7:0] input_format;
        logic [7:0] clock_mode_select;
        logic [8:0] active_video_delay;
        logic [7:0] black_level;
        logic [8:0] horizontal_offset;
        logic [8:0] vertical_offset;
        logic hsync_polarity;
        logic vsync_polarity;
        logic sync_output_control;
        logic decode_select;
        logic [2:0] power_down_field;
        logic soft_reset_n;
        logic rgb_output_enable_a;
        logic sense_trigger;
        logic [2:0] contrast_boost;
        logic [8:0] pll_feedback_divider;
        logic [9:0] pll_reference_divider;
        logic [5:0] clock_output_select;
        logic [31:0] subcarrier_increment;
        logic [5:0] pll_memory_control;
        logic auto_increment_calc_enable;
        logic [1:0] calc_hysteresis;
        logic [29:0] test_reserved;
    } tve_cfg_t;

endpackage : tve_pkg

// file: src/tve_register_bank.sv
// Purpose: Register bank of a digital PC to TV encoder
// Assumes: Serial front end delivers address byte, data byte and read-load events
// Notes: One event per cycle is expected; address byte outranks write, write outranks read

`timescale 1ns/1ps

module tve_register_bank #(
    parameter logic [7:0] VERSION_ID = 8'h5a // Arbitrary value
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Serial front end events
    input wire logic rab_valid,
    input wire logic [7:0] rab_byte,
    input wire logic wr_valid,
    input wire logic [7:0] wr_byte,
    input wire logic rd_load,
    output logic [7:0] rd_byte,
    output logic [5:0] register_pointer,
    // Status from the analog and calculation sections
    input wire logic [2:0] sense_result,
    input wire logic [25:0] calc_increment_value,
    // Control fields towards the datapath
    output tve_pkg::tve_cfg_t cfg
);

    // ****************************************
    // Decode functions
    // ****************************************
    function automatic logic [7:0] write_mask(input logic [5:0] addr);
        logic [7:0] m;
        m = 8'h00;
        unique case (addr)
            tve_pkg::A_DISPLAY_MODE, tve_pkg::A_BANDWIDTH, tve_pkg::A_CLOCK_MODE,
            tve_pkg::A_AV_DELAY, tve_pkg::A_BLACK_LEVEL, tve_pkg::A_H_OFFSET,
            tve_pkg::A_V_OFFSET, tve_pkg::A_PLL_FB, tve_pkg::A_PLL_REF,
            tve_pkg::A_TEST_FIRST: m = tve_pkg::M_FULL;
            tve_pkg::A_FLICKER, tve_pkg::A_CLK_OUT, tve_pkg::A_PLL_MEM,
            tve_pkg::A_TEST_1: m = tve_pkg::M_SIX;
            tve_pkg::A_INPUT_FORMAT: m = tve_pkg::M_INPUT;
            tve_pkg::A_POS_OVERFLOW: m = tve_pkg::M_THREE;
            tve_pkg::A_CONTRAST: m = tve_pkg::M_THREE;
            tve_pkg::A_SYNC_POL: m = tve_pkg::M_FOUR;
            tve_pkg::A_POWER, tve_pkg::A_PLL_HIGH: m = tve_pkg::M_FIVE;
            // Detect results are driven by the sensing circuit
            tve_pkg::A_CONN_SENSE: m = tve_pkg::M_ONE;
            tve_pkg::A_CALC_CTRL: m = tve_pkg::M_THREE;
            tve_pkg::A_TEST_2, tve_pkg::A_TEST_LAST: m = tve_pkg::M_FULL;
            default:
            begin
                if (addr >= tve_pkg::A_SUBC_FIRST && addr <= tve_pkg::A_SUBC_LAST)
                begin
                    m = tve_pkg::M_FOUR;
                end
                else
                begin
                    m = 8'h00;
                end
            end
        endcase
        return m;
    endfunction : write_mask

    function automatic logic [7:0] read_value(
        input tve_pkg::tve_state_t s,
        input logic [5:0] addr,
        input logic [2:0] sense,
        input logic [25:0] calc
    );
        logic [7:0] v;
        v = 8'h00;
        if (addr == tve_pkg::A_POINTER)
        begin
            v = {2'b00, s.ptr};
        end
        else if (addr == tve_pkg::A_FLICKER)
        begin
            // Luma and text fields swap places on readback
            v = {s.mem[addr][7:4], s.mem[addr][1:0], s.mem[addr][3:2]};
        end
        else if (addr == tve_pkg::A_CONN_SENSE)
        begin
            v = {4'h0, sense, s.mem[addr][0]};
        end
        else if (addr == tve_pkg::A_CALC_CTRL)
        begin
            v = {3'b000, calc[25:24], s.mem[addr][2:0]};
        end
        else if (addr == tve_pkg::A_CALC_HI)
        begin
            v = calc[23:16];
        end
        else if (addr == tve_pkg::A_CALC_MID)
        begin
            v = calc[15:8];
        end
        else if (addr == tve_pkg::A_CALC_LO)
        begin
            v = calc[7:0];
        end
        else if (addr == tve_pkg::A_VERSION)
        begin
            v = VERSION_ID;
        end
        else if (addr < 6'(tve_pkg::MEM_DEPTH))
        begin
            v = s.mem[addr] & write_mask(addr);
        end
        return v;
    endfunction : read_value

    // ****************************************
    // State
    // ****************************************
    tve_pkg::tve_state_t st;
    tve_pkg::tve_state_t next_st;
    logic [5:0] rd_addr;

    always_comb
    begin
        next_st = st;
        rd_addr = st.ptr;
        if (rab_valid)
        begin
            next_st.ptr = rab_byte[5:0];
            next_st.step_en = rab_byte[tve_pkg::POS_STEP_EN];
            next_st.first_read = 1'b1;
        end
        else if (wr_valid)
        begin
            if (st.ptr == tve_pkg::A_POINTER)
            begin
                // Byte written at the pointer restarts the sequence
                next_st.ptr = wr_byte[5:0];
            end
            else
            begin
                if (st.ptr < 6'(tve_pkg::MEM_DEPTH))
                begin
                    next_st.mem[st.ptr] = (st.mem[st.ptr] & ~write_mask(st.ptr))
                        | (wr_byte & write_mask(st.ptr));
                end
                if (st.step_en)
                begin
                    next_st.ptr = st.ptr + 6'h01;
                end
            end
        end
        else if (rd_load)
        begin
            if (st.step_en && !st.first_read)
            begin
                rd_addr = (st.ptr >= tve_pkg::A_READ_WRAP) ? tve_pkg::A_READ_START
                    : st.ptr + 6'h01;
            end
            next_st.ptr = rd_addr;
            next_st.first_read = 1'b0;
            next_st.rd_byte = read_value(st, rd_addr, sense_result, calc_increment_value);
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '0;
            st.ptr <= tve_pkg::RST_POINTER;
            st.step_en <= 1'b0;
            st.first_read <= 1'b1;
            st.rd_byte <= tve_pkg::RST_OTHER;
            st.mem[tve_pkg::A_DISPLAY_MODE] <= tve_pkg::RST_DISPLAY_MODE;
            st.mem[tve_pkg::A_FLICKER] <= tve_pkg::RST_FLICKER;
            st.mem[tve_pkg::A_POWER] <= tve_pkg::RST_POWER;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs, straight from state flops
    // ****************************************
    assign rd_byte = st.rd_byte;
    assign register_pointer = st.ptr;

    always_comb
    begin
        cfg.display_mode_select = st.mem[tve_pkg::A_DISPLAY_MODE];
        cfg.flicker_filter_select = st.mem[tve_pkg::A_FLICKER][5:0];
        cfg.video_bandwidth = st.mem[tve_pkg::A_BANDWIDTH];
        cfg.input_format = st.mem[tve_pkg::A_INPUT_FORMAT];
        cfg.clock_mode_select = st.mem[tve_pkg::A_CLOCK_MODE];
        cfg.active_video_delay = {st.mem[tve_pkg::A_POS_OVERFLOW][tve_pkg::POS_DELAY_MSB],
            st.mem[tve_pkg::A_AV_DELAY]};
        cfg.black_level = st.mem[tve_pkg::A_BLACK_LEVEL];
        cfg.horizontal_offset = {st.mem[tve_pkg::A_POS_OVERFLOW][tve_pkg::POS_HPOS_MSB],
            st.mem[tve_pkg::A_H_OFFSET]};
        cfg.vertical_offset = {st.mem[tve_pkg::A_POS_OVERFLOW][tve_pkg::POS_VPOS_MSB],
            st.mem[tve_pkg::A_V_OFFSET]};
        cfg.hsync_polarity = st.mem[tve_pkg::A_SYNC_POL][0];
        cfg.vsync_polarity = st.mem[tve_pkg::A_SYNC_POL][1];
        cfg.sync_output_control = st.mem[tve_pkg::A_SYNC_POL][2];
        cfg.decode_select = st.mem[tve_pkg::A_SYNC_POL][3];
        cfg.power_down_field = st.mem[tve_pkg::A_POWER][2:0];
        cfg.soft_reset_n = st.mem[tve_pkg::A_POWER][3];
        cfg.rgb_output_enable_a = st.mem[tve_pkg::A_POWER][4];
        cfg.sense_trigger = st.mem[tve_pkg::A_CONN_SENSE][0];
        cfg.contrast_boost = st.mem[tve_pkg::A_CONTRAST][2:0];
        cfg.pll_feedback_divider = {st.mem[tve_pkg::A_PLL_HIGH][tve_pkg::POS_FB_BIT8],
            st.mem[tve_pkg::A_PLL_FB]};
        cfg.pll_reference_divider = {st.mem[tve_pkg::A_PLL_HIGH][tve_pkg::POS_REF_HI],
            st.mem[tve_pkg::A_PLL_HIGH][tve_pkg::POS_REF_LO],
            st.mem[tve_pkg::A_PLL_REF]};
        cfg.clock_output_select = st.mem[tve_pkg::A_CLK_OUT][5:0];
        for (int i = 0; i < 8; i++)
        begin
            // Most significant nibble lives at the lowest address
            cfg.subcarrier_increment[28 - 4 * i +: 4] =
                st.mem[int'(tve_pkg::A_SUBC_FIRST) + i][3:0];
        end
        cfg.pll_memory_control = st.mem[tve_pkg::A_PLL_MEM][5:0];
        cfg.auto_increment_calc_enable = st.mem[tve_pkg::A_CALC_CTRL][0];
        cfg.calc_hysteresis = st.mem[tve_pkg::A_CALC_CTRL][2:1];
        // Test bits are exposed but nothing in normal operation uses them
        cfg.test_reserved = {st.mem[tve_pkg::A_TEST_LAST], st.mem[tve_pkg::A_TEST_2],
            st.mem[tve_pkg::A_TEST_1][5:0], st.mem[tve_pkg::A_TEST_FIRST]};
    end

endmodule : tve_register_bank

// file: dv/tve_host_model.sv
// Purpose: Byte event source standing in for the serial front end
// Assumes: Events are launched on the falling clock edge
// Notes: Idle byte lines carry the inverse of the last byte
`timescale 1ns/1ps
module tve_host_model (
    // Clock
    input wire logic mclk,
    // Byte events towards the bank
    output logic rab_valid,
    output logic [7:0] rab_byte,
    output logic wr_valid,
    output logic [7:0] wr_byte,
    output logic rd_load
);
    initial
    begin
        rab_valid = 1'b0;
        wr_valid = 1'b0;
        rd_load = 1'b0;
        rab_byte = 8'h00;
        wr_byte = 8'h00;
    end
    // ****
    // One pulse a call; kind 0 address, 1 write, 2 read load
    // ****
    task automatic send(input logic [1:0] kind, input logic [7:0] value);
        @(negedge mclk);
        rab_valid = (kind == 2'h0);
        wr_valid = (kind == 2'h1);
        rd_load = (kind == 2'h2);
        rab_byte = value;
        wr_byte = value;
        @(negedge mclk);
        rab_valid = 1'b0;
        wr_valid = 1'b0;
        rd_load = 1'b0;
        // Stale bytes must not look valid
        rab_byte = ~value;
        wr_byte = ~value;
    endtask : send
endmodule : tve_host_model

// file: dv/tve_chk.sv
// Purpose: Port checks of the register bank
// Assumes: One event per cycle, priority address, write, read
// Notes: Step mode is tracked from address bytes
`timescale 1ns/1ps
module tve_chk #(
    parameter logic [7:0] VERSION_ID = 8'h5a
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Events
    input wire logic rab_valid,
    input wire logic [7:0] rab_byte,
    input wire logic wr_valid,
    input wire logic [7:0] wr_byte,
    input wire logic rd_load,
    input wire logic [7:0] rd_byte,
    input wire logic [5:0] register_pointer,
    // Status and controls
    input wire logic [2:0] sense_result,
    input wire logic [25:0] calc_increment_value,
    input wire tve_pkg::tve_cfg_t cfg
);
    logic step_q;
    logic first_q;
    logic wr_ev;
    logic rd_ev;
    assign wr_ev = wr_valid && !rab_valid;
    assign rd_ev = rd_load && !rab_valid && !wr_valid;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            step_q <= 1'b0;
            first_q <= 1'b1;
        end
        else if (rab_valid)
        begin
            step_q <= rab_byte[6];
            first_q <= 1'b1;
        end
        else if (rd_ev)
            first_q <= 1'b0;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    chk_ptr_load: assert property (rab_valid
        |=> {2'b00, register_pointer} == ($past(rab_byte) & 8'h3f))
        else $error("pointer not loaded");
    chk_rd_hold: assert property (!rd_ev |=> $stable(rd_byte))
        else $error("read byte changed");
    chk_read_wrap: assert property (rd_ev && step_q && !first_q
        && register_pointer == 6'h2a |=> register_pointer == 6'h00)
        else $error("read pointer did not wrap");
    chk_step_off: assert property ((rd_ev || wr_ev && register_pointer != 6'h3f)
        && !step_q |=> $stable(register_pointer))
        else $error("pointer moved with stepping off");
    chk_wr_advance: assert property (wr_ev && step_q && register_pointer != 6'h3f
        |=> register_pointer == $past(register_pointer) + 6'h01)
        else $error("pointer not advanced");
    chk_new_start: assert property (wr_ev && register_pointer == 6'h3f
        |=> {2'b00, register_pointer} == ($past(wr_byte) & 8'h3f) ##0 $stable(cfg))
        else $error("start address not taken");
    chk_version_read: assert property (rd_ev && !step_q && register_pointer == 6'h25
        |=> rd_byte == VERSION_ID)
        else $error("version byte wrong");
    chk_pointer_read: assert property (rd_ev && !step_q && register_pointer == 6'h3f
        |=> rd_byte == {2'b00, $past(register_pointer)})
        else $error("pointer readback wrong");
    chk_sense_read: assert property (rd_ev && !step_q && register_pointer == 6'h10
        |=> rd_byte[3:1] == $past(sense_result))
        else $error("sense results wrong");
    chk_delay_low: assert property (wr_ev && register_pointer == 6'h07
        |=> cfg.active_video_delay[7:0] == $past(wr_byte))
        else $error("delay low byte wrong");
    cov_step_on: cover property (rab_valid && rab_byte[6]);
    cov_wrap: cover property (rd_ev && step_q && register_pointer == 6'h2a);
    cov_restart: cover property (wr_ev && register_pointer == 6'h3f);
endmodule : tve_chk
bind tve_register_bank tve_chk #(.VERSION_ID(VERSION_ID)) i_tve_chk (.mclk, .arst_n,
    .rab_valid, .rab_byte, .wr_valid, .wr_byte, .rd_load, .rd_byte, .register_pointer,
    .sense_result, .calc_increment_value, .cfg);

// file: dv/tve_register_bank_tb.sv
// Purpose: Self-checking bench of the register bank
// Assumes: Host model issues one byte event per call
// Notes: A shadow copy of written bytes, with the sense, calc, version and pointer values, predicts every read
`timescale 1ns/1ps
module tve_register_bank_tb;
    localparam logic [7:0] ver_id = 8'h3c; // Arbitrary value
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic rab_valid, wr_valid, rd_load, step, first;
    logic [7:0] rab_byte, wr_byte, rd_byte;
    logic [5:0] register_pointer, a;
    logic [2:0] sense = 3'h0;
    logic [25:0] calc = 26'h0;
    tve_pkg::tve_cfg_t cfg;
    logic [7:0] shadow [0:41];
    logic [31:0] fsc;
    integer seed = 32'h420ee4b0;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    always #50 mclk = ~mclk;
    tve_host_model i_tve_host_model (.mclk, .rab_valid, .rab_byte, .wr_valid, .wr_byte,
        .rd_load);
    tve_register_bank #(.VERSION_ID(ver_id)) i_tve_register_bank (.mclk, .arst_n, .rab_valid,
        .rab_byte, .wr_valid, .wr_byte, .rd_load, .rd_byte, .register_pointer,
        .sense_result(sense), .calc_increment_value(calc), .cfg);
    // ****
    // Expectations
    // ****
    function automatic logic [7:0] wmask(input logic [5:0] x);
        case (x)
            6'h00, 6'h03, 6'h06, 6'h07, 6'h09, 6'h0a, 6'h0b: return 8'hff;
            6'h14, 6'h15, 6'h26, 6'h28, 6'h29: return 8'hff;
            6'h01, 6'h17, 6'h20, 6'h27: return 8'h3f;
            6'h04: return 8'h6f;
            6'h08, 6'h11, 6'h21: return 8'h07;
            6'h0d: return 8'h0f;
            6'h0e, 6'h13: return 8'h1f;
            6'h10: return 8'h01;
            default: return (x >= 6'h18 && x <= 6'h1f) ? 8'h0f : 8'h00;
        endcase
    endfunction : wmask
    function automatic logic [7:0] exp_rd(input logic [5:0] x);
        logic [7:0] s;
        s = (x < 6'h2a) ? shadow[x] : 8'h00;
        case (x)
            6'h01: return {s[7:4], s[1:0], s[3:2]};
            6'h10: return {4'h0, sense, s[0]};
            6'h21: return {3'h0, calc[25:24], s[2:0]};
            6'h22: return calc[23:16];
            6'h23: return calc[15:8];
            6'h24: return calc[7:0];
            6'h25: return ver_id;
            6'h3f: return {2'b00, x};
            default: return s;
        endcase
    endfunction : exp_rd
    // ****
    // Transfers
    // ****
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            miscompares++;
        end
    endtask : check
    task automatic addr(input logic [7:0] v);
        i_tve_host_model.send(2'h0, v);
        a = v[5:0];
        step = v[6];
        first = 1'b1;
    endtask : addr
    task automatic put(input logic [7:0] v);
        i_tve_host_model.send(2'h1, v);
        if (a == 6'h3f)
            a = v[5:0];
        else
        begin
            if (a < 6'h2a)
                shadow[a] = v & wmask(a);
            if (step)
                a = a + 6'h01;
        end
        check("pointer", register_pointer, a);
    endtask : put
    task automatic get;
        if (step && !first)
            a = (a >= 6'h2a) ? 6'h00 : a + 6'h01;
        first = 1'b0;
        i_tve_host_model.send(2'h2, 8'h00);
        check("read byte", rd_byte, exp_rd(a));
        check("pointer", register_pointer, a);
    endtask : get
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            stop_test();
        end
    end
    // ****
    // Scenarios
    // ****
    initial
    begin
        for (int i = 0; i < 42; i++)
            shadow[i] = 8'h00;
        shadow[0] = 8'h6a;
        shadow[1] = 8'h32;
        shadow[14] = 8'h08;
        repeat (6) @(negedge mclk);
        arst_n = 1'b1;
        // Reset value, write, readback of each address, stepping off
        for (int i = 0; i <= 42; i++)
        begin
            sense = 3'($random(seed));
            calc = 26'($random(seed));
            addr({2'b00, 6'(i)});
            get();
            put(8'($random(seed)));
            get();
        end
        addr(8'h3f);
        get();
        // Stepping writes over the map, stepping reads across the wrap
        addr(8'h40);
        for (int i = 0; i < 42; i++)
            put(8'($random(seed)));
        addr(8'h40);
        for (int i = 0; i < 44; i++)
            get();
        // Byte written at the pointer register restarts at 07h
        addr(8'h7e);
        put(8'haa);
        put(8'h47);
        put(8'h5c);
        addr(8'h07);
        get();
        fsc = 32'h0;
        for (int i = 24; i < 32; i++)
            fsc = {fsc[27:0], shadow[i][3:0]};
        check("delay", cfg.active_video_delay, {shadow[8][2], shadow[7]});
        check("hpos", cfg.horizontal_offset, {shadow[8][1], shadow[10]});
        check("vpos", cfg.vertical_offset, {shadow[8][0], shadow[11]});
        check("fb div", cfg.pll_feedback_divider, {shadow[19][0], shadow[20]});
        check("ref div", cfg.pll_reference_divider, {shadow[19][2:1], shadow[21]});
        check("subcarrier", cfg.subcarrier_increment, fsc);
        check("sync", {cfg.decode_select, cfg.sync_output_control, cfg.vsync_polarity,
            cfg.hsync_polarity}, shadow[13]);
        check("power", {cfg.rgb_output_enable_a, cfg.soft_reset_n,
            cfg.power_down_field}, shadow[14]);
        check("calc ctl", {cfg.calc_hysteresis, cfg.auto_increment_calc_enable},
            shadow[33][2:0]);
        check("plain", {cfg.display_mode_select, cfg.video_bandwidth, cfg.clock_mode_select,
            cfg.black_level}, {shadow[0], shadow[3], shadow[6], shadow[9]});
        check("misc", {cfg.flicker_filter_select, cfg.input_format, cfg.sense_trigger,
            cfg.contrast_boost, cfg.clock_output_select, cfg.pll_memory_control},
            {shadow[1][5:0], shadow[4], shadow[16][0], shadow[17][2:0], shadow[23][5:0],
            shadow[32][5:0]});
        check("test", cfg.test_reserved, {shadow[41], shadow[40], shadow[39][5:0],
            shadow[38]});
        stop_test();
    end
endmodule : tve_register_bank_tb
